// ### rtl/spdf_pkg.sv
// Constants, field layout and types for the sawtooth PWM channel.
// Assumes every user writes spdf_pkg::name; nothing is imported.
package spdf_pkg;
	localparam int unsigned DW = 32;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_CMP_A  = 8'h08;
	localparam logic [7:0] OFS_CMP_B  = 8'h0c;
	localparam logic [7:0] OFS_BUF_C  = 8'h10;
	localparam logic [7:0] OFS_BUF_D  = 8'h14;
	localparam logic [7:0] OFS_DT_UP  = 8'h18;
	localparam logic [7:0] OFS_DT_DN  = 8'h1c;
	localparam logic [7:0] OFS_FORCE  = 8'h20;
	localparam logic [7:0] OFS_ACTION = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_COUNT  = 8'h2c;
	// Control register bits.
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_DBUF  = 1;
	localparam int CTRL_ADT   = 2;
	localparam int CTRL_FXFER = 3;
	// Duty force control bits.
	localparam int FRC_A_LSB = 0;
	localparam int FRC_B_LSB = 2;
	localparam int FAS_A_BIT = 4;
	localparam int REL_A_BIT = 5;
	localparam int REL_B_BIT = 6;
	localparam logic [1:0] FRC_LOW  = 2'h2;
	localparam logic [1:0] FRC_HIGH = 2'h3;
	// Pin action fields; pin B sits PIN_B_OFS bits above pin A.
	localparam int START_BIT = 0;
	localparam int CM_LSB    = 1;
	localparam int END_LSB   = 3;
	localparam int PIN_B_OFS = 8;
	// Status bits.
	localparam int ST_RUN  = 0;
	localparam int ST_OVF  = 1;
	localparam int ST_CMA  = 2;
	localparam int ST_CMB  = 3;
	localparam int ST_PINA = 4;
	localparam int ST_PINB = 5;
	// Reset values.
	localparam logic [31:0] RST_PERIOD = 32'h0000_00ff;
	localparam logic [15:0] RST_ACTION = 16'h010c;
	localparam logic [6:0]  RST_FORCE  = 7'h00;
	typedef enum logic [1:0] {
		SPDF_ACT_HOLD = 2'h0,
		SPDF_ACT_LOW  = 2'h1,
		SPDF_ACT_HIGH = 2'h2,
		SPDF_ACT_TOG  = 2'h3
	} spdf_act_type;
	typedef enum logic [1:0] {
		SPDF_ST_IDLE = 2'b01,
		SPDF_ST_RUN  = 2'b10
	} spdf_state_type;
endpackage

// ### rtl/spdf_top.sv
// Sawtooth PWM channel with forced 0%/100% duty and an APB slave.
// Assumes an APB master on i_ref_clk; pins drive external loads.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1 - auto dead time derives B compare from A
// RULE2 - software orders up-count buffers with dead time
// RULE3 - software orders down-count buffers with dead time
// RULE4 - software keeps buffers between zero and period
// RULE5 - full duty only through force fields; the code also gives it from a high match on the period count
// RULE6 - zero compare gives one-cycle pulse
// RULE7 - compare action beats overflow on same count
// RULE8 - matching and transfers continue while forced
// RULE9 - release level from end action and mode
// RULE10 - end action 00b holds pin level
// RULE11 - release mode 1 uses masked compare value
// RULE12 - force-at-start applies force at count start
// RULE13 - force 11b gives high from next period
// RULE14 - single buffer C feeds compare A
// RULE15 - start level, match and end actions programmable
// RULE16 - count from zero to period then overflow
// RULE17 - each overflow raises overflow interrupt
// RULE18 - force 00b returns to compare duty
// RULE19 - double buffer one-shot transfers
// RULE20 - force without force-at-start ignored at start
// RULE21 - compare above period never matches
// RULE22 - overflow copies buffer C into compare A
module spdf_top (
	// Clock and reset.
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Pins and overflow event.
	output logic             o_output_pin_a,
	output logic             o_output_pin_b,
	output logic             o_overflow_interrupt
);
	// Applies a two-bit pin action to the current level.
	function automatic logic act_apply(input logic [1:0] act, input logic cur);
		case (spdf_pkg::spdf_act_type'(act))
			spdf_pkg::SPDF_ACT_LOW:  act_apply = 1'b0;
			spdf_pkg::SPDF_ACT_HIGH: act_apply = 1'b1;
			spdf_pkg::SPDF_ACT_TOG:  act_apply = ~cur;
			default:                 act_apply = cur;
		endcase
	endfunction

	logic [2:0]  ctrl_ff, nxt_ctrl;
	logic [31:0] period_ff, nxt_period, cmp_a_ff, nxt_cmp_a;
	logic [31:0] cmp_b_ff, nxt_cmp_b, buf_c_ff, nxt_buf_c;
	logic [31:0] buf_d_ff, nxt_buf_d, temp_ff, nxt_temp;
	logic [31:0] dtu_ff, nxt_dtu, dtd_ff, nxt_dtd;
	logic [6:0]  frc_ff, nxt_frc;
	logic [15:0] act_ff, nxt_act;
	logic [31:0] cnt_ff, nxt_cnt;
	spdf_pkg::spdf_state_type state_ff, nxt_state;
	logic [2:0]  flag_ff, nxt_flag;
	logic        irq_ff, nxt_irq;
	logic [31:0] prdata_ff, nxt_prdata, cmp_b_eff;
	logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic        wr, running, start, ovf, fxfer;
	logic [1:0]  match;
	logic [1:0]  eff_ff [2], nxt_eff [2];
	logic        cmv_ff [2], nxt_cmv [2];
	logic        pin_ff [2], nxt_pin [2];

	// Shared decode; the write strobe is taken only at the access edge.
	assign wr      = i_psel & i_penable & pready_ff & i_pwrite;
	assign running = (state_ff == spdf_pkg::SPDF_ST_RUN);
	assign start   = (state_ff == spdf_pkg::SPDF_ST_IDLE) & ctrl_ff[spdf_pkg::CTRL_RUN];
	assign ovf     = running & (cnt_ff == period_ff);
	assign fxfer   = wr & (i_paddr == spdf_pkg::OFS_CTRL)
		& i_pwdata[spdf_pkg::CTRL_FXFER];
	assign cmp_b_eff = ctrl_ff[spdf_pkg::CTRL_ADT] ? cmp_a_ff + dtu_ff
		: cmp_b_ff; // RULE1
	// Equality alone means a value above the period never matches.
	assign match[0] = running & (cnt_ff == cmp_a_ff); // RULE21
	assign match[1] = running & (cnt_ff == cmp_b_eff);

	// Counter and run state; a stopped counter restarts from zero.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			spdf_pkg::SPDF_ST_IDLE: begin
				nxt_cnt = 32'h0000_0000; // RULE16
				if (ctrl_ff[spdf_pkg::CTRL_RUN]) begin
					nxt_state = spdf_pkg::SPDF_ST_RUN;
				end
			end
			spdf_pkg::SPDF_ST_RUN: begin
				nxt_cnt = ovf ? 32'h0000_0000 : cnt_ff + 32'h0000_0001; // RULE16
				if (!ctrl_ff[spdf_pkg::CTRL_RUN]) begin
					nxt_state = spdf_pkg::SPDF_ST_IDLE;
				end
			end
			default: nxt_state = spdf_pkg::SPDF_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff <= spdf_pkg::SPDF_ST_IDLE;
			cnt_ff   <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end
	// Register writes, then hardware transfers, which win over software.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_period = period_ff;
		nxt_cmp_a = cmp_a_ff;
		nxt_cmp_b = cmp_b_ff;
		nxt_buf_c = buf_c_ff;
		nxt_buf_d = buf_d_ff;
		nxt_temp = temp_ff;
		nxt_dtu = dtu_ff;
		nxt_dtd = dtd_ff;
		nxt_frc = frc_ff;
		nxt_act = act_ff;
		if (wr) begin
			case (i_paddr)
				spdf_pkg::OFS_CTRL:   nxt_ctrl = i_pwdata[2:0];
				spdf_pkg::OFS_PERIOD: nxt_period = i_pwdata;
				spdf_pkg::OFS_CMP_A:  nxt_cmp_a = i_pwdata;
				spdf_pkg::OFS_CMP_B:  nxt_cmp_b = i_pwdata;
				spdf_pkg::OFS_BUF_C:  nxt_buf_c = i_pwdata;
				spdf_pkg::OFS_BUF_D:  nxt_buf_d = i_pwdata;
				spdf_pkg::OFS_DT_UP:  nxt_dtu = i_pwdata;
				spdf_pkg::OFS_DT_DN:  nxt_dtd = i_pwdata;
				spdf_pkg::OFS_FORCE:  nxt_frc = i_pwdata[6:0];
				spdf_pkg::OFS_ACTION: nxt_act = i_pwdata[15:0];
				default: nxt_ctrl = ctrl_ff;
			endcase
		end
		// Transfers keep running under force; only the pin is masked.
		if (fxfer) begin
			nxt_temp  = buf_d_ff;
			nxt_cmp_a = buf_c_ff;
		end else if (ctrl_ff[spdf_pkg::CTRL_DBUF]) begin
			if (ovf) begin
				nxt_temp  = buf_d_ff; // RULE19 RULE8
				nxt_cmp_a = buf_c_ff; // RULE19
			end else if (match[0]) begin
				nxt_cmp_a = temp_ff; // RULE19
			end
		end else if (ovf) begin
			nxt_cmp_a = buf_c_ff; // RULE14 RULE22 RULE8
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_ff <= 3'h0;
			period_ff <= spdf_pkg::RST_PERIOD;
			cmp_a_ff <= 32'h0000_0000;
			cmp_b_ff <= 32'h0000_0000;
			buf_c_ff <= 32'h0000_0000;
			buf_d_ff <= 32'h0000_0000;
			temp_ff <= 32'h0000_0000;
			dtu_ff <= 32'h0000_0000;
			dtd_ff <= 32'h0000_0000;
			frc_ff <= spdf_pkg::RST_FORCE;
			act_ff <= spdf_pkg::RST_ACTION;
		end else begin
			ctrl_ff <= nxt_ctrl;
			period_ff <= nxt_period;
			cmp_a_ff <= nxt_cmp_a;
			cmp_b_ff <= nxt_cmp_b;
			buf_c_ff <= nxt_buf_c;
			buf_d_ff <= nxt_buf_d;
			temp_ff <= nxt_temp;
			dtu_ff <= nxt_dtu;
			dtd_ff <= nxt_dtd;
			frc_ff <= nxt_frc;
			act_ff <= nxt_act;
		end
	end
	// One pin each: compare-driven level, latched force and the pin.
	for (genvar p = 0; p < 2; p++) begin : g_pin
		localparam int B = p * spdf_pkg::PIN_B_OFS;
		logic [1:0] frc;
		logic       rel, fas;
		assign frc = frc_ff[spdf_pkg::FRC_A_LSB + 2 * p +: 2];
		assign rel = frc_ff[spdf_pkg::REL_A_BIT + p];
		assign fas = (p == 0) & frc_ff[spdf_pkg::FAS_A_BIT];
		always_comb begin
			nxt_eff[p] = eff_ff[p];
			nxt_cmv[p] = cmv_ff[p];
			if (start) begin
				nxt_cmv[p] = act_ff[B + spdf_pkg::START_BIT]; // RULE15
				nxt_eff[p] = fas ? frc : 2'h0; // RULE12 RULE20
			end else if (running) begin
				// Compare action wins over the end action on one count.
				if (match[p]) begin
					nxt_cmv[p] = act_apply(act_ff[B + spdf_pkg::CM_LSB +: 2],
						cmv_ff[p]); // RULE7 RULE6 RULE15
				end else if (ovf) begin
					nxt_cmv[p] = act_apply(act_ff[B + spdf_pkg::END_LSB +: 2],
						cmv_ff[p]); // RULE9 RULE10 RULE11
				end
				if (ovf) begin
					nxt_eff[p] = frc; // RULE13 RULE18 RULE17
					if (eff_ff[p][1] & !frc[1] & !rel) begin
						nxt_cmv[p] = eff_ff[p][0]; // RULE9
					end
				end
			end
			// A force code overrides the compare level at the pin; a high match on the period count gives full duty.
			nxt_pin[p] = nxt_eff[p][1] ? nxt_eff[p][0] : nxt_cmv[p]; // RULE5
			if (!start && !running) begin
				nxt_pin[p] = pin_ff[p];
			end
		end
		always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
			if (i_sys_rst) begin
				eff_ff[p] <= 2'h0;
				cmv_ff[p] <= 1'b0;
				pin_ff[p] <= 1'b0;
			end else begin
				eff_ff[p] <= nxt_eff[p];
				cmv_ff[p] <= nxt_cmv[p];
				pin_ff[p] <= nxt_pin[p];
			end
		end
	end

	// Sticky event flags; a new event beats a same-cycle clear.
	always_comb begin
		logic [2:0] clr;
		clr = 3'h0;
		if (wr && i_paddr == spdf_pkg::OFS_STATUS) begin
			clr = i_pwdata[spdf_pkg::ST_CMB:spdf_pkg::ST_OVF];
		end
		nxt_flag = (flag_ff & ~clr) | {match[1], match[0], ovf}; // RULE8
		nxt_irq  = ovf; // RULE17
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			flag_ff <= 3'h0;
			irq_ff  <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			irq_ff  <= nxt_irq;
		end
	end
	// Read data is sampled in setup so pready can come from a flop.
	always_comb begin
		nxt_pready  = i_psel & ~i_penable;
		nxt_pslverr = 1'b0;
		nxt_prdata  = prdata_ff;
		if (nxt_pready) begin
			nxt_prdata = 32'h0000_0000;
			case (i_paddr)
				spdf_pkg::OFS_CTRL:   nxt_prdata[2:0] = ctrl_ff;
				spdf_pkg::OFS_PERIOD: nxt_prdata = period_ff;
				spdf_pkg::OFS_CMP_A:  nxt_prdata = cmp_a_ff;
				spdf_pkg::OFS_CMP_B:  nxt_prdata = cmp_b_eff;
				spdf_pkg::OFS_BUF_C:  nxt_prdata = buf_c_ff;
				spdf_pkg::OFS_BUF_D:  nxt_prdata = buf_d_ff;
				spdf_pkg::OFS_DT_UP:  nxt_prdata = dtu_ff;
				spdf_pkg::OFS_DT_DN:  nxt_prdata = dtd_ff;
				spdf_pkg::OFS_FORCE:  nxt_prdata[6:0] = frc_ff;
				spdf_pkg::OFS_ACTION: nxt_prdata[15:0] = act_ff;
				spdf_pkg::OFS_STATUS: nxt_prdata[5:0] = {pin_ff[1],
					pin_ff[0], flag_ff, running};
				spdf_pkg::OFS_COUNT:  nxt_prdata = cnt_ff;
				default: nxt_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end
	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_output_pin_a = pin_ff[0];
	assign o_output_pin_b = pin_ff[1];
	assign o_overflow_interrupt = irq_ff;
	// Checks on the counter wrap, interrupt, pin and transfer behaviour.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_ovf_single;
		ovf && !ctrl_ff[spdf_pkg::CTRL_DBUF] && !fxfer;
	endsequence
	sequence s_start_low;
		start && frc_ff[spdf_pkg::FAS_A_BIT] && frc_ff[1:0] == spdf_pkg::FRC_LOW;
	endsequence
	ovf_wrap_a: assert property (ovf |=> cnt_ff == 32'h0000_0000) // RULE16
		else $error("Counter did not wrap to zero.");
	ovf_irq_a: assert property (ovf |=> // RULE17
		o_overflow_interrupt ##1 !o_overflow_interrupt || ovf)
		else $error("Overflow pulse missing.");
	single_xfer_a: assert property (s_ovf_single |=> // RULE22
		cmp_a_ff == $past(buf_c_ff))
		else $error("Buffer C not copied at overflow.");
	dbuf_match_a: assert property (match[0] && !ovf && !fxfer // RULE19
		&& ctrl_ff[spdf_pkg::CTRL_DBUF] |=> cmp_a_ff == $past(temp_ff))
		else $error("Temporary value not loaded on match.");
	force_high_a: assert property (ovf // RULE13
		&& frc_ff[1:0] == spdf_pkg::FRC_HIGH |=> o_output_pin_a [*2])
		else $error("Forced high missing after overflow.");
	start_low_a: assert property (s_start_low ##1 !match[0] |-> // RULE12
		!o_output_pin_a)
		else $error("Force at start did not hold pin low.");
	no_start_frc_a: assert property (start // RULE20
		&& !frc_ff[spdf_pkg::FAS_A_BIT] |=> eff_ff[0] == 2'h0)
		else $error("Force applied at start without force-at-start.");
	cm_prio_a: assert property (match[0] && ovf // RULE7
		&& !frc_ff[1] && !eff_ff[0][1] && act_ff[2:1] == 2'h3 |=>
		cmv_ff[0] != $past(cmv_ff[0]))
		else $error("Overflow beat compare match.");
	// The derived B match must move the B level, not just the match strobe.
	dead_time_a: assert property (running && !eff_ff[1][1] // RULE1
		&& ctrl_ff[spdf_pkg::CTRL_ADT] && act_ff[10:9] == 2'h2
		&& cnt_ff == cmp_a_ff + dtu_ff |=> cmv_ff[1])
		else $error("Derived B compare did not raise the B level.");
endmodule // spdf_top
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the sawtooth PWM channel, APB master included.
// Assumes spdf_pkg and spdf_top are compiled first; one clock, no partner.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic        i_ref_clk, i_sys_rst, i_psel, i_penable, i_pwrite, er;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        o_pready, o_pslverr, o_output_pin_a, o_output_pin_b;
	logic        o_overflow_interrupt;
	int          n_mismatch, n_checks, cyc, hi, hib, irq, seed, p, c, e;

	spdf_top dut (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_output_pin_a(o_output_pin_a),
		.o_output_pin_b(o_output_pin_b),
		.o_overflow_interrupt(o_overflow_interrupt)
	);

	// Free-running 20 MHz clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	// A hang is cut short here so the verdict is always printed.
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer; entered just after a rising edge, holds until pready.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready.
		do begin
			@(posedge i_ref_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		// An idle edge keeps the next setup from re-raising psel at once.
		@(posedge i_ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input int d);
		apb(1'b1, a, 32'(d));
	endtask

	task automatic rdw(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Counts high cycles and overflow pulses over n whole cycles.
	task automatic meas(input int n);
		hi = 0;
		hib = 0;
		irq = 0;
		repeat (n) begin
			@(negedge i_ref_clk);
			hi += int'(o_output_pin_a === 1'b1);
			hib += int'(o_output_pin_b === 1'b1);
			irq += int'(o_overflow_interrupt === 1'b1);
		end
		@(posedge i_ref_clk);
	endtask

	task automatic rst();
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_ref_clk);
	endtask

	// Fresh start: period, buffers loaded by a forced transfer, then run.
	task automatic run(input int pp, input int cc, input int dd,
		input int f, input int act, input int x);
		rst();
		wr(spdf_pkg::OFS_PERIOD, pp);
		wr(spdf_pkg::OFS_BUF_C, cc);
		wr(spdf_pkg::OFS_BUF_D, dd);
		wr(spdf_pkg::OFS_CTRL, 8);
		wr(spdf_pkg::OFS_FORCE, f);
		wr(spdf_pkg::OFS_ACTION, act);
		wr(spdf_pkg::OFS_CTRL, 1 | x);
	endtask

	// Main sequence; reset values and a bad address first, then random duties, corner cases after.
	initial begin
		seed = 32'h2e89;
		i_sys_rst = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		rst();
		rdw(spdf_pkg::OFS_PERIOD);
		`CHK(rd, spdf_pkg::RST_PERIOD)
		rdw(spdf_pkg::OFS_ACTION);
		`CHK(rd, 32'(spdf_pkg::RST_ACTION))
		rdw(spdf_pkg::OFS_FORCE);
		`CHK(rd, 32'(spdf_pkg::RST_FORCE))
		wr(8'h30, 1);
		`CHK(er, 1'b1)
		rdw(8'h30);
		`CHK(rd, 32'h0)
		// Index 0 is a zero compare, index 1 lies above the period.
		for (int i = 0; i < 8; i++) begin
			p = 4 + ($unsigned($random(seed)) % 12);
			c = 1 + ($unsigned($random(seed)) % (p - 1));
			if (i < 2)
				c = i * (p + 2);
			run(p, c, p, 0, 32'h010c, 0);
			meas(2 * (p + 1));
			meas(3 * (p + 1));
			e = (c > p) ? 0 : 3 * (p - c);
			`CHK(hi, e)
			`CHK(irq, 3)
			rdw(spdf_pkg::OFS_CMP_A);
			`CHK(rd, 32'(c))
		end
		// Force high on A and low on B while running, then release.
		run(7, 3, 5, 0, 32'h010c, 0);
		meas(16);
		wr(spdf_pkg::OFS_FORCE, 32'h0b);
		meas(16);
		wr(spdf_pkg::OFS_STATUS, 32'h0c);
		meas(24);
		`CHK(hi, 24)
		`CHK(hib, 0)
		rdw(spdf_pkg::OFS_STATUS);
		`CHK(rd[spdf_pkg::ST_CMA], 1'b1)
		wr(spdf_pkg::OFS_FORCE, 32'h60);
		meas(16);
		meas(24);
		`CHK(hi, 12)
		// Toggle on match with a held end level alternates whole periods.
		run(7, 3, 5, 0, 32'h0106, 0);
		meas(16);
		meas(32);
		`CHK(hi, 16)
		// A match on the overflow count toggles instead of ending low.
		run(7, 7, 7, 0, 32'h010e, 0);
		meas(16);
		meas(16);
		`CHK(hi, 8)
		// Force-at-start holds A low from the very first count.
		run(7, 3, 5, 32'h12, 32'h010c, 0);
		meas(24);
		`CHK(hi, 0)
		// Without force-at-start the first period follows the compare.
		run(7, 3, 5, 32'h03, 32'h010c, 0);
		meas(8);
		`CHK(hi, 4)
		// Automatic dead time derives the B compare; B mirrors A's actions.
		run(9, 3, 6, 0, 32'h0c0c, 4);
		wr(spdf_pkg::OFS_DT_UP, 2);
		meas(20);
		meas(20);
		`CHK(hi, 12)
		`CHK(hib, 8)
		rdw(spdf_pkg::OFS_CMP_B);
		`CHK(rd, 32'h5)
		// Double buffering toggles at C and again at D each period.
		run(9, 2, 6, 0, 32'h010e, 2);
		meas(20);
		meas(20);
		`CHK(hi, 8)
		test_done();
	end
endmodule // tb_top
`default_nettype wire
